// file: core/drb_core.sv
// Purpose: command decode, refresh, posted column commands and burst data framing
// Assumes: command pins synchronous to sys_clk_i; one beat pair per clock on dq
// Notes:   dq carries {fall beat, rise beat}; the array answers reads combinationally
`timescale 1ns/1ps
`include "drb_params.svh"
module drb_core #(
   parameter int DEPTH = 12
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [1:0] ba_i,
   input wire logic [11:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic [15:0] arr_rdata_i,
   output drb_pkg::drb_arr_t arr_o,
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   output logic dqs_oe_o,
   output logic dqs_pre_o,
   output logic refresh_o,
   output logic [11:0] refresh_row_o,
   output logic [3:0] bank_open_o
);
   import drb_pkg::*;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   drb_cmd_e_t cmd;
   logic [3:0] pins;
   assign pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

   // the stop pattern (ras, cas high, we low) has no meaning here
   always_comb begin
      case (pins)
         4'h0: cmd = CMD_MRS;
         4'h1: cmd = CMD_REF;
         4'h2: cmd = CMD_PRE;
         4'h3: cmd = CMD_ACT;
         4'h4: cmd = CMD_WR;
         4'h5: cmd = CMD_RD;
         4'h6: cmd = CMD_IGN;
         4'h7: cmd = CMD_NOP;
         default: cmd = CMD_DESEL;
      endcase
   end

   wire is_mrs = (cmd == CMD_MRS);
   wire is_ref = (cmd == CMD_REF);
   wire is_act = (cmd == CMD_ACT);
   wire is_pre = (cmd == CMD_PRE);
   wire is_col = (cmd == CMD_RD) || (cmd == CMD_WR);
   wire is_nop = (cmd == CMD_NOP);

   // ----------------------------------------------------------------
   // mode registers
   // ----------------------------------------------------------------
   logic bl8;
   logic interleave;
   logic [2:0] cl;
   logic [2:0] al;
   wire [2:0] bl_code = addr_i[`DRB_MR_BL_MSB:`DRB_MR_BL_LSB];
   wire [2:0] cl_field = addr_i[`DRB_MR_CL_MSB:`DRB_MR_CL_LSB];
   wire [2:0] al_field = addr_i[`DRB_EMR_AL_MSB:`DRB_EMR_AL_LSB];
   wire mr_load = is_mrs && (ba_i == `DRB_BA_MR);
   wire emr_load = is_mrs && (ba_i == `DRB_BA_EMR1);
   wire [2:0] next_cl = (cl_field < `DRB_CL_MIN) ? `DRB_CL_MIN : cl_field;
   wire [2:0] next_al = (al_field > `DRB_AL_MAX) ? `DRB_AL_MAX : al_field;

   // unsupported burst codes leave the previous length in force
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bl8 <= 1'b0;
         interleave <= 1'b0;
         cl <= `DRB_CL_RST;
         al <= `DRB_AL_RST;
      end else begin
         if (mr_load) begin
            if (bl_code == `DRB_BL8_CODE || bl_code == `DRB_BL4_CODE) begin
               bl8 <= (bl_code == `DRB_BL8_CODE);
            end
            interleave <= addr_i[`DRB_MR_BT_BIT];
            cl <= next_cl;
         end
         if (emr_load) begin
            al <= next_al;
         end
      end
   end

   // ----------------------------------------------------------------
   // refresh and bank state
   // ----------------------------------------------------------------
   logic [11:0] row_cnt;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         row_cnt <= `DRB_ROW_RST;
         refresh_o <= 1'b0;
         refresh_row_o <= `DRB_ROW_RST;
         bank_open_o <= 4'h0;
      end else begin
         refresh_o <= is_ref;
         if (is_ref) begin
            refresh_row_o <= row_cnt;
            row_cnt <= row_cnt + 12'h001;
            bank_open_o <= 4'h0;
         end else if (is_act) begin
            bank_open_o[ba_i] <= 1'b1;
         end else if (is_pre) begin
            if (addr_i[`DRB_AP_BIT]) begin
               bank_open_o <= 4'h0;
            end else begin
               bank_open_o[ba_i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // posted column commands
   // ----------------------------------------------------------------
   // held by a delay line tapped at al + cl less a fixed offset; taps move with the latencies
   drb_col_t pipe [0:DEPTH-1];
   drb_col_t next_entry;
   assign next_entry = '{vld: is_col, wr: ~we_n_i, ba: ba_i, col: addr_i[9:0]};

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            pipe[i] <= '0;
         end
      end else begin
         pipe[0] <= next_entry;
         for (int i = 1; i < DEPTH; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   wire [3:0] rl = {1'b0, al} + {1'b0, cl};
   wire [3:0] rd_idx = rl - `DRB_RD_TAP_OFS;
   wire [3:0] wr_idx = rl - `DRB_WR_TAP_OFS;
   drb_col_t rd_tap;
   drb_col_t wr_tap;
   assign rd_tap = pipe[rd_idx];
   assign wr_tap = pipe[wr_idx];
   wire load_wr = wr_tap.vld && wr_tap.wr;
   wire load_rd = rd_tap.vld && !rd_tap.wr;

   // ----------------------------------------------------------------
   // burst engine
   // ----------------------------------------------------------------
   logic eng_act;
   logic eng_wr;
   logic eng_bl8;
   logic [1:0] eng_pair;
   logic [1:0] eng_ba;
   logic [9:0] eng_col;
   logic [9:0] col_rise;
   logic [9:0] col_fall;
   wire [1:0] pair_last = eng_bl8 ? `DRB_PAIR_LAST_BL8 : `DRB_PAIR_LAST_BL4;

   drb_burst_seq u_seq (
      .start_col_i(eng_col),
      .pair_i(eng_pair),
      .bl8_i(eng_bl8),
      .interleave_i(interleave),
      .col_rise_o(col_rise),
      .col_fall_o(col_fall)
   );

   // a new load simply restarts the engine: that is the only interruption
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         eng_act <= 1'b0;
         eng_wr <= 1'b0;
         eng_bl8 <= 1'b0;
         eng_pair <= 2'h0;
         eng_ba <= 2'h0;
         eng_col <= 10'h000;
      end else if (load_wr || load_rd) begin
         eng_act <= 1'b1;
         eng_wr <= load_wr;
         eng_bl8 <= bl8;
         eng_pair <= 2'h0;
         eng_ba <= load_wr ? wr_tap.ba : rd_tap.ba;
         eng_col <= load_wr ? wr_tap.col : rd_tap.col;
      end else if (eng_act) begin
         eng_act <= (eng_pair != pair_last);
         eng_pair <= eng_pair + 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // array access and data framing
   // ----------------------------------------------------------------
   wire next_pre = eng_act && !eng_wr && (eng_pair == 2'h0) && !arr_o.rd;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         arr_o <= '0;
         dq_o <= 16'h0000;
         dq_oe_o <= 1'b0;
         dqs_oe_o <= 1'b0;
         dqs_pre_o <= 1'b0;
      end else begin
         arr_o.rd <= eng_act && !eng_wr;
         arr_o.wr <= eng_act && eng_wr;
         arr_o.ba <= eng_ba;
         arr_o.col_rise <= col_rise;
         arr_o.col_fall <= col_fall;
         arr_o.wdata <= dq_i;
         dq_o <= arr_rdata_i;
         dq_oe_o <= arr_o.rd;
         dqs_pre_o <= next_pre;
         dqs_oe_o <= next_pre || arr_o.rd;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_refresh_row: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      is_ref |=> refresh_o && (refresh_row_o == $past(row_cnt)))
      else $error("refresh row not taken from counter");

   chk_refresh_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      is_ref |=> (bank_open_o == 4'h0))
      else $error("banks not idle after refresh");

   chk_nop_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      is_nop |=> $stable(bank_open_o) && $stable(al) && $stable(cl) && !refresh_o && !pipe[0].vld)
      else $error("nop changed state");

   chk_deselect_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cs_n_i |=> !refresh_o && !pipe[0].vld && $stable(bank_open_o))
      else $error("deselect reached decoder");

   chk_burst_group: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (arr_o.rd || arr_o.wr) |-> ((((arr_o.col_rise ^ $past(eng_col)) | (arr_o.col_fall ^ $past(eng_col)))
         & ($past(eng_bl8) ? `DRB_GRP8_MASK : `DRB_GRP4_MASK)) == 10'h000))
      else $error("burst left its column group");

   chk_seq_order: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ((arr_o.rd || arr_o.wr) && !interleave) |-> (arr_o.col_fall[1:0] == arr_o.col_rise[1:0] + 2'h1))
      else $error("sequential order broken");

   chk_read_latency: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      ((cmd == CMD_RD) && (rl == 4'h5)) |-> ##5 arr_o.rd ##1 dq_oe_o)
      else $error("read data not at read latency");

   chk_preamble_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      dqs_pre_o |-> dqs_oe_o && !dq_oe_o ##1 dq_oe_o && dqs_oe_o && !dqs_pre_o)
      else $error("strobe preamble not one clock before data");

   chk_write_stops: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!eng_act && !load_wr) |=> !arr_o.wr)
      else $error("write data taken after burst end");

   chk_al_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      al <= `DRB_AL_MAX)
      else $error("additive latency out of range");

endmodule : drb_core

// file: common/drb_params.svh
// Purpose: constants for the ddr2 refresh and burst access core
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef DRB_PARAMS_SVH
`define DRB_PARAMS_SVH

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define DRB_BA_MR 2'h0
`define DRB_BA_EMR1 2'h1
`define DRB_MR_BL_MSB 2
`define DRB_MR_BL_LSB 0
`define DRB_MR_BT_BIT 3
`define DRB_MR_CL_MSB 6
`define DRB_MR_CL_LSB 4
`define DRB_EMR_AL_MSB 5
`define DRB_EMR_AL_LSB 3
`define DRB_AP_BIT 10
`define DRB_GRP8_MASK 10'h3f8
`define DRB_GRP4_MASK 10'h3fc
`define DRB_BL4_CODE 3'h2
`define DRB_BL8_CODE 3'h3

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define DRB_CL_RST 3'h3
`define DRB_CL_MIN 3'h3
`define DRB_AL_RST 3'h0
`define DRB_AL_MAX 3'h6
`define DRB_ROW_RST 12'h000

// ----------------------------------------------------------------
// timing taps
// ----------------------------------------------------------------
`define DRB_RD_TAP_OFS 4'h3
`define DRB_WR_TAP_OFS 4'h2
`define DRB_PAIR_LAST_BL4 2'h1
`define DRB_PAIR_LAST_BL8 2'h3

`endif

// file: common/drb_pkg.sv
// Purpose: types shared by the ddr2 burst access core
// Assumes: nothing
// Notes:   constants live in drb_params.svh
package drb_pkg;

   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_IGN
   } drb_cmd_e_t;

   typedef struct packed {
      logic vld;
      logic wr;
      logic [1:0] ba;
      logic [9:0] col;
   } drb_col_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] ba;
      logic [9:0] col_rise;
      logic [9:0] col_fall;
      logic [15:0] wdata;
   } drb_arr_t;

endpackage : drb_pkg

// file: core/drb_burst_seq.sv
// Purpose: column addresses of one beat pair within a burst
// Assumes: pair counts 0..3 for eight beats, 0..1 for four
// Notes:   purely combinational
`timescale 1ns/1ps
module drb_burst_seq (
   input wire logic [9:0] start_col_i,
   input wire logic [1:0] pair_i,
   input wire logic bl8_i,
   input wire logic interleave_i,
   output logic [9:0] col_rise_o,
   output logic [9:0] col_fall_o
);

   function automatic logic [9:0] beat_col(input logic [9:0] st, input logic [2:0] idx,
                                           input logic b8, input logic il);
      logic [2:0] low;
      low = 3'h0;
      if (il) begin
         low = st[2:0] ^ idx;
      end else begin
         low[1:0] = st[1:0] + idx[1:0];
         low[2] = b8 ? (st[2] ^ idx[2]) : st[2];
      end
      beat_col = {st[9:3], low};
   endfunction : beat_col

   // the upper bits never change, so a burst stays in its aligned group
   assign col_rise_o = beat_col(start_col_i, {pair_i, 1'b0}, bl8_i, interleave_i);
   assign col_fall_o = beat_col(start_col_i, {pair_i, 1'b1}, bl8_i, interleave_i);

endmodule : drb_burst_seq

// file: verification/drb_array_model.sv
// Purpose: array stand-in that answers beat pair reads with an address pattern
// Assumes: the core asks for one beat pair per cycle with rd high
// Notes:   data off the read strobe is inverted so a late sample cannot match
`timescale 1ns/1ps
module drb_array_model
   import drb_pkg::*;
(
   input wire drb_pkg::drb_arr_t arr_i,
   output logic [15:0] rdata_o
);
   import drb_pkg::*;
   logic [15:0] pattern;

   // bank and upper column bits take part so a wrong group or bank shows up
   assign pattern = {arr_i.col_fall[7:0] ^ {arr_i.col_fall[9:8], arr_i.ba, 4'h6},
                     arr_i.col_rise[7:0] ^ {arr_i.col_rise[9:8], arr_i.ba, 4'h6}};
   assign rdata_o = arr_i.rd ? pattern : ~pattern;
endmodule : drb_array_model

// file: verification/tb_ddr2_refresh_and_burst_access.sv
// Purpose: self-checking bench for drb_core, acting as the memory controller
// Assumes: default DEPTH covers read latency up to thirteen
// Notes:   expected pairs are queued with their due cycle and popped by a monitor
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_ddr2_refresh_and_burst_access;
   import drb_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cs_n, ras_n, cas_n, we_n, dq_oe, dqs_oe, dqs_pre, refresh, prev_oe, prev_pre;
   logic [1:0] ba;
   logic [11:0] addr, refresh_row, row_first;
   logic [15:0] dq_i, arr_rdata, dq_o;
   logic [3:0] bank_open;
   logic [9:0] s;
   logic [47:0] rv;
   logic [69:0] wv;
   drb_arr_t arr;
   int cyc, miscompares, cmp_count, al, cl, bl8, il, e0, b;
   logic [47:0] rq[$];
   logic [47:0] dq_q[$];
   logic [69:0] wq[$];

   initial forever #2 sys_clk_i = ~sys_clk_i;

   drb_core i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
      .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dq_i(dq_i), .arr_rdata_i(arr_rdata), .arr_o(arr), .dq_o(dq_o),
      .dq_oe_o(dq_oe), .dqs_oe_o(dqs_oe), .dqs_pre_o(dqs_pre), .refresh_o(refresh),
      .refresh_row_o(refresh_row), .bank_open_o(bank_open));
   drb_array_model i_arr (.arr_i(arr), .rdata_o(arr_rdata));

   always @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) cyc <= 0;
      else cyc <= cyc + 1;
   end

   function automatic logic [9:0] colf(input logic [9:0] st, input int k);
      logic [2:0] kk;
      kk = 3'(k);
      if (il != 0) return {st[9:3], st[2:0] ^ kk};
      return {st[9:3], st[2] ^ kk[2], st[1:0] + kk[1:0]};
   endfunction : colf

   function automatic logic [7:0] pat(input logic [1:0] bk, input logic [9:0] c);
      return c[7:0] ^ {c[9:8], bk, 4'h6};
   endfunction : pat

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge sys_clk_i);
         {ras_n, cas_n, we_n, ba, addr} = 17'($urandom);
         case ($urandom % 3)
            0: cs_n = 1'b1;
            1: {cs_n, ras_n, cas_n, we_n} = 4'h7;
            default: {cs_n, ras_n, cas_n, we_n} = 4'h6;
         endcase
      end
   endtask : idle

   task automatic issue(input logic [2:0] c, input logic [1:0] bk, input logic [11:0] a);
      @(negedge sys_clk_i);
      {cs_n, ras_n, cas_n, we_n, ba, addr} = {1'b0, c, bk, a};
      e0 = cyc + 1;
   endtask : issue

   task automatic push_rd(input logic [1:0] bk, input logic [9:0] st, input int pairs);
      for (int k = 0; k < pairs; k++) begin
         rq.push_back({32'(e0 + al + cl + k), pat(bk, colf(st, 2 * k + 1)), pat(bk, colf(st, 2 * k))});
      end
   endtask : push_rd

   task automatic push_wr(input logic [1:0] bk, input logic [9:0] st, input int pairs);
      logic [15:0] d;
      for (int k = 0; k < pairs; k++) begin
         d = 16'($urandom);
         dq_q.push_back({32'(e0 + al + cl + k), d});
         wq.push_back({32'(e0 + al + cl + k), bk, colf(st, 2 * k), colf(st, 2 * k + 1), d});
      end
   endtask : push_wr

   // pairs are driven in the cycle before their capture edge; other cycles carry junk
   always @(negedge sys_clk_i) begin
      if (dq_q.size() > 0 && dq_q[0][47:16] == 32'(cyc + 1)) begin
         dq_i <= dq_q[0][15:0];
         dq_q.pop_front();
      end else begin
         dq_i <= 16'($urandom);
      end
   end

   // ----------------------------------------------------------------
   // checking
   // ----------------------------------------------------------------
   always @(negedge sys_clk_i) begin
      if (!reset_i) begin
         if (dq_oe === 1'b1) begin
            `CHK(rq.size() > 0, 1'b1)
            if (rq.size() > 0) begin
               rv = rq.pop_front();
               `CHK({32'(cyc), dq_o}, rv)
               if (prev_oe !== 1'b1) `CHK(prev_pre, 1'b1)
               `CHK(dqs_oe, 1'b1)
            end
         end
         if (arr.wr === 1'b1) begin
            `CHK(wq.size() > 0, 1'b1)
            if (wq.size() > 0) begin
               wv = wq.pop_front();
               `CHK({32'(cyc), arr.ba, arr.col_rise, arr.col_fall, arr.wdata}, wv)
            end
         end
      end
      prev_oe <= dq_oe;
      prev_pre <= dqs_pre;
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   initial begin
      #100000;
      miscompares++;
      results();
   end

   initial begin
      {cs_n, ras_n, cas_n, we_n, ba, addr} = '1;
      void'($urandom(32'h71bbfb98));
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i) reset_i = 1'b0;
      issue(3'h3, 2'h1, 12'($urandom));
      issue(3'h3, 2'h2, 12'($urandom));
      idle(2);
      `CHK(bank_open, 4'h6)
      issue(3'h2, 2'h1, 12'h000);
      idle(1);
      `CHK(bank_open, 4'h4)
      issue(3'h1, 2'($urandom), 12'($urandom));
      idle(1);
      `CHK({refresh, bank_open}, 5'h10)
      row_first = refresh_row;
      idle(13);
      `CHK(refresh, 1'b0)
      issue(3'h1, 2'($urandom), 12'($urandom));
      idle(2);
      `CHK(refresh_row !== row_first, 1'b1)
      for (al = 0; al <= 6; al++) begin
         for (int m = 0; m < 4; m++) begin
            bl8 = m / 2;
            il = m % 2;
            cl = 3 + $urandom % 5;
            b = $urandom % 4;
            issue(3'h0, 2'h0, {5'h0, 3'(cl), 1'(il), bl8 != 0 ? 3'h3 : 3'h2});
            issue(3'h0, 2'h1, {6'h0, 3'(al), 3'h0});
            issue(3'h3, 2'(b), 12'($urandom));
            s = 10'($urandom);
            issue(3'h5, 2'(b), {2'h0, s});
            push_rd(2'(b), s, 2);
            idle(1);
            s = 10'($urandom);
            issue(3'h5, 2'(b), {2'h0, s});
            push_rd(2'(b), s, bl8 != 0 ? 4 : 2);
            idle(al + cl + 6);
            s = 10'($urandom);
            issue(3'h4, 2'(b), {2'h0, s});
            push_wr(2'(b), s, 2);
            idle(1);
            s = 10'($urandom);
            issue(3'h4, 2'(b), {2'h0, s});
            push_wr(2'(b), s, bl8 != 0 ? 4 : 2);
            idle(al + cl + 8);
         end
      end
      // refused codes: a bad length keeps eight beats, latencies clamp to their limits
      al = 6;
      cl = 3;
      il = 0;
      issue(3'h0, 2'h0, {5'h0, 3'h1, 1'b0, 3'h7});
      issue(3'h0, 2'h1, {6'h0, 3'h7, 3'h0});
      issue(3'h3, 2'h0, 12'($urandom));
      s = 10'($urandom);
      issue(3'h5, 2'h0, {2'h0, s});
      push_rd(2'h0, s, 4);
      idle(20);
      `CHK(rq.size() + wq.size(), 0)
      results();
   end
endmodule : tb_ddr2_refresh_and_burst_access
